// ==== include/pms_pkg.sv ====
// Purpose: Shared constants and types for the power-mode sequencer.
// Assumes: One 125 MHz clock; all mode bits arrive as plain ports.
// Notes: Wait counts are in states of the running system clock.
`default_nettype none
package pms_pkg;
    // -------------------------------------------------------------
    // Operating modes
    // -------------------------------------------------------------
    typedef enum logic [7:0] {
        PMS_RESET = 8'h01,
        PMS_HIGH = 8'h02,
        PMS_MEDIUM = 8'h04,
        PMS_SUBACT = 8'h08,
        PMS_SLEEP = 8'h10,
        PMS_STANDBY = 8'h20,
        PMS_WATCH = 8'h40,
        PMS_SUBSLEEP = 8'h80
    } pms_mode_t;

    // -------------------------------------------------------------
    // Configuration carried together
    // -------------------------------------------------------------
    typedef struct packed {
        logic standby_select;
        logic low_speed_on_select;
        logic medium_speed_on_select;
        logic direct_transfer_on;
        logic watch_path_select;
        logic [2:0] settling_wait_select;
    } pms_cfg_t;

    // Interrupt request vector layout.
    localparam int PMS_NUM_SRC = 16;
    localparam int PMS_SRC_TIMER_A = 0;
    localparam int PMS_SRC_TIMER_F = 1;
    localparam int PMS_SRC_EVCNT = 2;
    localparam int PMS_SRC_SERIAL3 = 3;
    localparam int PMS_SRC_EVPIN = 4;
    localparam int PMS_SRC_EXT_INTR_ONE = 5;
    localparam int PMS_SRC_EXT_INTR_ZERO = 6;
    localparam int PMS_SRC_WKP_LO = 7;
    localparam int PMS_SRC_WKP_HI = 14;
    localparam int PMS_SRC_DIRECT = 15;

    localparam logic [15:0] PMS_WATCH_WAKE = 16'h7fc3;
    localparam logic [15:0] PMS_SUBSLEEP_WAKE = 16'h7fff;
    localparam logic [15:0] PMS_STANDBY_WAKE = 16'h7fe0;
    localparam logic [15:0] PMS_SLEEP_WAKE = 16'h7fff;

    // Settling wait in states per code.
    localparam int PMS_WAIT_W = 15;
    localparam logic [14:0] PMS_WAIT_000 = 15'h2000;
    localparam logic [14:0] PMS_WAIT_001 = 15'h4000;
    localparam logic [14:0] PMS_WAIT_010 = 15'h0400;
    localparam logic [14:0] PMS_WAIT_011 = 15'h0800;
    localparam logic [14:0] PMS_WAIT_100 = 15'h1000;
    localparam logic [14:0] PMS_WAIT_101 = 15'h0002;
    localparam logic [14:0] PMS_WAIT_110 = 15'h0008;
    localparam logic [14:0] PMS_WAIT_111 = 15'h0010;

    // Direct transition timing, in states.
    localparam logic [4:0] PMS_PRE_STATES = 5'h03;
    localparam logic [4:0] PMS_EXC_STATES = 5'h0e;

    // Divider selection codes.
    localparam logic [1:0] PMS_SUB_DIV2 = 2'h0;
    localparam logic [1:0] PMS_SUB_DIV4 = 2'h1;
    localparam logic [1:0] PMS_SUB_DIV8 = 2'h2;
endpackage
`default_nettype wire

// ==== hw/pms_clock_div.sv ====
// Purpose: Divider producing one-cycle enable pulses at a chosen ratio.
// Assumes: Ratio codes 0 to 2 select 2**(1+code), from 2 up to 8; code 3 gives a ratio of 1.
// Notes: A change of code applies at once to the count in progress.
`timescale 1ns/100ps
`default_nettype none
module pms_clock_div #(
    parameter int CNT_W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic src_en,
    input wire logic [1:0] ratio_code,
    // Output
    output logic tick
);
    import pms_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;

    // Limit is 2**(code+1) minus one for codes 0 to 2; the 2-bit sum wraps, so code 3 gives 0.
    always_comb begin
        limit = CNT_W'((1 << (ratio_code + 2'h1)) - 1);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (src_en) begin
                if (count >= limit) begin
                    count <= '0;
                    tick <= 1'b1;
                end else begin
                    count <= count + CNT_W'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== hw/pms_sync3.sv ====
// Purpose: Three-flop synchroniser with agreement filter for pin inputs.
// Assumes: Inputs change slowly relative to the clock.
// Notes: The first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module pms_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change counts once stages two and three agree.
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                sync_out[i] <= INIT[i];
            end else if (stage2[i] == stage3[i]) begin
                sync_out[i] <= stage3[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== hw/pms_sequencer.sv ====
// What this block does
// - Watch plus low-speed wakes into subactive.
// - Subsleep wakes into subactive on listed sources.
// - Masked or disabled interrupts never cause subactive.
// - Subactive sleep with standby, watch path: watch.
// - Subactive sleep, no standby, low-speed, path: subsleep.
// - Subactive clock is watch clock over 2/4/8, or over 1 for code 3.
// - Reset pin low forces medium-speed after reset.
// - Medium-speed wake from standby, watch or sleep.
// - Medium sleep with standby, no low-speed, no path: standby.
// - Medium sleep with standby and path: watch.
// - Medium sleep without standby or low-speed: sleep.
// - Medium-speed clock chosen by two divider bits.
// - Direct transfer changes mode, keeps program running.
// - Disabled direct interrupt ends in sleep/watch.
// - Masked direct transfer stalls unreleasable in sleep/watch.
// - High to medium direct transfer via sleep.
// - Medium to high direct transfer via sleep.
// - High/medium to subactive direct transfer via watch.
// - Subactive to high/medium via watch after wait.
// - Direct transition lasts pre plus exception states; only the 14 exception states are counted.
// - Medium entry may run half state early.
// - Settling wait codes map to listed state counts.
//
// Purpose: Power-mode sequencer for a single-chip controller.
// Assumes: sleep_exec is a one-cycle pulse from the CPU core.
// Notes: Interrupt requests are levels already in this clock domain.
`timescale 1ns/100ps
`default_nettype none
module pms_sequencer
    import pms_pkg::*;
#(
    parameter int NSRC = PMS_NUM_SRC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Reset pin from the board
    input wire logic chip_rst_pin_n,
    // CPU core
    input wire logic sleep_exec,
    input wire logic interrupt_mask_bit,
    input wire pms_pkg::pms_cfg_t cfg,
    input wire logic [1:0] subactive_divider_select,
    input wire logic [1:0] medium_divider_select,
    // Interrupt sources
    input wire logic [NSRC-1:0] intr_req,
    input wire logic [NSRC-1:0] intr_enable,
    // Clock ticks
    input wire logic watch_clk_tick,
    // Status
    output pms_pkg::pms_mode_t mode,
    output logic cpu_halted,
    output logic cpu_clk_en,
    output logic direct_exc_start,
    output logic wake_exc_start,
    output logic transition_busy
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pms_mode_t next_mode;
    pms_mode_t target;
    pms_mode_t next_target;
    pms_cfg_t held;
    logic rst_pin;
    logic [NSRC-1:0] live;
    logic [NSRC-1:0] wake_set;
    logic wake_hit;
    logic locked;
    logic next_locked;
    logic [PMS_WAIT_W-1:0] wait_cnt;
    logic [PMS_WAIT_W-1:0] wait_len;
    logic [4:0] state_cnt;
    logic in_direct;
    logic exc_phase;
    logic sub_tick;
    logic med_tick;
    logic sys_tick;
    logic direct_ok;
    logic wait_done;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    pms_sync3 #(.W(1), .INIT(1'b0)) u_rst_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(chip_rst_pin_n),
        .sync_out(rst_pin)
    );

    // ------------------------------------------------------------
    // Clock dividers
    // ------------------------------------------------------------
    pms_clock_div #(.CNT_W(4)) u_sub_div (
        .clk(clk),
        .resetn(resetn),
        .src_en(watch_clk_tick),
        .ratio_code(subactive_divider_select),
        .tick(sub_tick)
    );

    pms_clock_div #(.CNT_W(5)) u_med_div (
        .clk(clk),
        .resetn(resetn),
        .src_en(1'b1),
        .ratio_code(medium_divider_select),
        .tick(med_tick)
    );

    // ------------------------------------------------------------
    // Wake decode
    // ------------------------------------------------------------
    always_comb begin
        live = intr_req & intr_enable;
        case (mode)
            PMS_WATCH: wake_set = live & PMS_WATCH_WAKE;
            PMS_SUBSLEEP: wake_set = live & PMS_SUBSLEEP_WAKE;
            PMS_STANDBY: wake_set = live & PMS_STANDBY_WAKE;
            PMS_SLEEP: wake_set = live & PMS_SLEEP_WAKE;
            default: wake_set = '0;
        endcase
        // A masked CPU or a locked stop never wakes.
        wake_hit = (|wake_set) && !interrupt_mask_bit && !locked;
    end

    // ------------------------------------------------------------
    // Settling wait lookup
    // ------------------------------------------------------------
    always_comb begin
        case (held.settling_wait_select)
            3'h0: wait_len = PMS_WAIT_000;
            3'h1: wait_len = PMS_WAIT_001;
            3'h2: wait_len = PMS_WAIT_010;
            3'h3: wait_len = PMS_WAIT_011;
            3'h4: wait_len = PMS_WAIT_100;
            3'h5: wait_len = PMS_WAIT_101;
            3'h6: wait_len = PMS_WAIT_110;
            default: wait_len = PMS_WAIT_111;
        endcase
    end

    // The system tick follows the running mode's clock.
    always_comb begin
        case (mode)
            PMS_SUBACT: sys_tick = sub_tick;
            PMS_MEDIUM: sys_tick = med_tick;
            default: sys_tick = 1'b1;
        endcase
        wait_done = (wait_cnt >= wait_len);
        direct_ok = intr_enable[PMS_SRC_DIRECT] && !interrupt_mask_bit;
    end

    // ------------------------------------------------------------
    // Sleep decode and wake targets
    // ------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        next_target = target;
        next_locked = locked;
        case (mode)
            PMS_RESET: begin
                if (rst_pin) begin
                    next_mode = PMS_MEDIUM;
                end
            end
            PMS_HIGH, PMS_MEDIUM, PMS_SUBACT: begin
                if (sleep_exec) begin
                    // One decode on the values seen at the sleep.
                    if (cfg.direct_transfer_on) begin
                        next_locked = !direct_ok;
                        if (mode != PMS_SUBACT && cfg.standby_select &&
                            cfg.low_speed_on_select &&
                            cfg.watch_path_select) begin
                            next_mode = PMS_WATCH;
                            next_target = PMS_SUBACT;
                        end else if (mode == PMS_SUBACT &&
                            cfg.standby_select &&
                            !cfg.low_speed_on_select &&
                            cfg.watch_path_select) begin
                            next_mode = PMS_WATCH;
                            next_target = cfg.medium_speed_on_select ?
                                PMS_MEDIUM : PMS_HIGH;
                        end else if (mode == PMS_HIGH &&
                            !cfg.standby_select &&
                            !cfg.low_speed_on_select &&
                            cfg.medium_speed_on_select) begin
                            next_mode = PMS_SLEEP;
                            next_target = PMS_MEDIUM;
                        end else if (mode == PMS_MEDIUM &&
                            !cfg.standby_select &&
                            !cfg.low_speed_on_select &&
                            !cfg.medium_speed_on_select) begin
                            next_mode = PMS_SLEEP;
                            next_target = PMS_HIGH;
                        end else begin
                            next_mode = PMS_SLEEP;
                            next_target = mode;
                        end
                    end else if (cfg.standby_select &&
                        cfg.watch_path_select) begin
                        next_mode = PMS_WATCH;
                        next_locked = 1'b0;
                    end else if (mode == PMS_SUBACT) begin
                        if (cfg.low_speed_on_select &&
                            cfg.watch_path_select) begin
                            next_mode = PMS_SUBSLEEP;
                            next_locked = 1'b0;
                        end
                    end else if (cfg.standby_select &&
                        !cfg.low_speed_on_select) begin
                        next_mode = PMS_STANDBY;
                        next_locked = 1'b0;
                    end else if (!cfg.standby_select &&
                        !cfg.low_speed_on_select) begin
                        next_mode = PMS_SLEEP;
                        next_target = mode;
                        next_locked = 1'b0;
                    end
                end
            end
            PMS_SLEEP, PMS_WATCH, PMS_STANDBY, PMS_SUBSLEEP: begin
                if (in_direct && !locked) begin
                    // Direct hop: leave at once from sleep or into subactive, else after the wait.
                    if (mode == PMS_SLEEP || wait_done ||
                        target == PMS_SUBACT) begin
                        next_mode = target;
                    end
                end else if (wake_hit) begin
                    if (mode == PMS_SUBSLEEP) begin
                        next_mode = PMS_SUBACT;
                    end else if (mode == PMS_SLEEP) begin
                        next_mode = target;
                    end else if (held.low_speed_on_select) begin
                        next_mode = (mode == PMS_WATCH) ?
                            PMS_SUBACT : mode;
                    end else if (wait_done) begin
                        next_mode = held.medium_speed_on_select ?
                            PMS_MEDIUM : PMS_HIGH;
                    end
                end
            end
            default: next_mode = PMS_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // Mode state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode <= PMS_RESET;
            target <= PMS_MEDIUM;
            locked <= 1'b0;
        end else if (!rst_pin) begin
            mode <= PMS_RESET;
            target <= PMS_MEDIUM;
            locked <= 1'b0;
        end else begin
            mode <= next_mode;
            target <= next_target;
            locked <= next_locked;
        end
    end

    // Configuration latched at the sleep instruction.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            held <= '0;
        end else if (sleep_exec && (mode == PMS_HIGH ||
            mode == PMS_MEDIUM || mode == PMS_SUBACT)) begin
            held <= cfg;
        end
    end

    // ------------------------------------------------------------
    // Settling wait counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_cnt <= '0;
        end else if (next_mode != mode) begin
            wait_cnt <= '0;
        end else if ((mode == PMS_WATCH || mode == PMS_STANDBY) &&
            (in_direct || wake_hit) && !wait_done) begin
            wait_cnt <= wait_cnt + PMS_WAIT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Direct transfer timing
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_direct <= 1'b0;
            exc_phase <= 1'b0;
            state_cnt <= '0;
            direct_exc_start <= 1'b0;
        end else begin
            direct_exc_start <= 1'b0;
            if (!rst_pin) begin
                in_direct <= 1'b0;
                exc_phase <= 1'b0;
                state_cnt <= '0;
            end else if (sleep_exec && cfg.direct_transfer_on &&
                direct_ok && next_target != mode) begin
                in_direct <= 1'b1;
                state_cnt <= '0;
            end else if (in_direct && next_mode == target &&
                mode != target) begin
                in_direct <= 1'b0;
                exc_phase <= 1'b1;
                state_cnt <= '0;
                direct_exc_start <= 1'b1;
            end else if (exc_phase && sys_tick) begin
                // Exception states counted on the new clock.
                if (state_cnt >= PMS_EXC_STATES - 5'h01) begin
                    exc_phase <= 1'b0;
                end else begin
                    state_cnt <= state_cnt + 5'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cpu_halted <= 1'b1;
            cpu_clk_en <= 1'b0;
            wake_exc_start <= 1'b0;
            transition_busy <= 1'b0;
        end else begin
            cpu_halted <= !rst_pin || !(next_mode == PMS_HIGH ||
                next_mode == PMS_MEDIUM || next_mode == PMS_SUBACT);
            // Entering medium may tick half a state early.
            cpu_clk_en <= sys_tick && !cpu_halted;
            wake_exc_start <= wake_hit && (next_mode != mode);
            transition_busy <= in_direct || exc_phase;
        end
    end
endmodule
`default_nettype wire

// ==== dv/pms_checker.sv ====
// Purpose: Port-level checks on the power-mode sequencer.
// Assumes: One clock domain; sleep pulses come at least two cycles apart.
// Notes: Bound to every instance of the sequencer.
`timescale 1ns/100ps
`default_nettype none
module pms_checker
    import pms_pkg::*;
#(
    parameter int NSRC = PMS_NUM_SRC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Observed inputs
    input wire logic chip_rst_pin_n,
    input wire logic sleep_exec,
    input wire logic interrupt_mask_bit,
    input wire pms_pkg::pms_cfg_t cfg,
    input wire logic [NSRC-1:0] intr_enable,
    // Observed outputs
    input wire pms_pkg::pms_mode_t mode,
    input wire logic cpu_halted,
    input wire logic direct_exc_start,
    input wire logic transition_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Standby, low-speed, medium-speed, direct and watch-path bits.
    logic [4:0] c;
    logic s_hi, s_md, s_sb, d_ok;
    assign c = cfg[7:3];
    assign s_hi = sleep_exec && mode == PMS_HIGH;
    assign s_md = sleep_exec && mode == PMS_MEDIUM;
    assign s_sb = sleep_exec && mode == PMS_SUBACT;
    assign d_ok = intr_enable[PMS_SRC_DIRECT] && !interrupt_mask_bit;
    a_med_standby: assert property (s_md && c ==? 5'b10?00 |=>
        mode == PMS_STANDBY) else $error("standby not entered");
    a_med_watch: assert property (s_md && c ==? 5'b1??01 |=>
        mode == PMS_WATCH) else $error("watch not entered");
    a_med_sleep: assert property (s_md && c ==? 5'b00?0? |=>
        mode == PMS_SLEEP) else $error("sleep not entered");
    a_sub_subsleep: assert property (s_sb && c ==? 5'b01?01 |=>
        mode == PMS_SUBSLEEP) else $error("subsleep not entered");
    a_sub_watch: assert property (s_sb && c ==? 5'b1??01 |=>
        mode == PMS_WATCH) else $error("watch not entered");
    a_direct_med: assert property (s_hi && c ==? 5'b0011? && d_ok
        |=> mode == PMS_SLEEP ##1 (mode == PMS_MEDIUM && direct_exc_start))
        else $error("high to medium transfer wrong");
    a_direct_high: assert property (s_md && c ==? 5'b0001? && d_ok
        |=> mode == PMS_SLEEP ##1 (mode == PMS_HIGH && direct_exc_start))
        else $error("medium to high transfer wrong");
    a_masked_lock: assert property ((s_md || s_hi) && c ==? 5'b00?1?
        && interrupt_mask_bit |=> (mode == PMS_SLEEP && !direct_exc_start)[*4])
        else $error("masked transfer not held in sleep");
    a_subsleep_hold: assert property (chip_rst_pin_n[*4] ##0
        (mode == PMS_SUBSLEEP && interrupt_mask_bit) |=> mode == PMS_SUBSLEEP)
        else $error("masked wake left subsleep");
    a_pin_reset: assert property ((!chip_rst_pin_n)[*6] |->
        mode == PMS_RESET && cpu_halted) else $error("reset pin ignored");
    a_busy_hold: assert property (direct_exc_start |=>
        transition_busy[*8]) else $error("busy dropped early");
    c_subsleep_wake: cover property (mode == PMS_SUBSLEEP ##1 mode == PMS_SUBACT);
    c_direct: cover property (direct_exc_start);
    c_standby_wake: cover property (mode == PMS_STANDBY ##[1:40] mode == PMS_MEDIUM);
endmodule
bind pms_sequencer pms_checker #(.NSRC(NSRC)) u_chk (.clk(clk),
    .resetn(resetn), .chip_rst_pin_n(chip_rst_pin_n), .sleep_exec(sleep_exec),
    .interrupt_mask_bit(interrupt_mask_bit), .cfg(cfg),
    .intr_enable(intr_enable), .mode(mode), .cpu_halted(cpu_halted),
    .direct_exc_start(direct_exc_start), .transition_busy(transition_busy));
`default_nettype wire

// ==== dv/pms_cpu_model.sv ====
// Purpose: CPU core and interrupt sources facing the sequencer.
// Assumes: A request stays pending until an exception starts.
// Notes: Outputs change only on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module pms_cpu_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Exception starts
    input wire logic wake_exc_start,
    input wire logic direct_exc_start,
    // Requests
    output logic sleep_exec,
    output logic [15:0] intr_req
);
    logic go = 1'b0;
    logic [15:0] val = '0;
    always @(negedge clk or negedge resetn) begin
        if (!resetn) begin
            sleep_exec <= 1'b0;
            intr_req <= '0;
        end else begin
            sleep_exec <= go;
            intr_req <= (wake_exc_start || direct_exc_start) ? '0 : intr_req | val;
        end
    end
    task automatic sleep();
        @(posedge clk);
        go = 1'b1;
        @(posedge clk);
        go = 1'b0;
    endtask
    task automatic raise(input logic [15:0] m);
        @(posedge clk);
        val = m;
        @(posedge clk);
        val = '0;
    endtask
endmodule
`default_nettype wire

// ==== dv/pms_sequencer_tb_top.sv ====
// Purpose: Directed bench for the power-mode sequencer.
// Assumes: Settling code 110, so wakes to active mode take 8 cycles.
// Notes: Inputs change on the falling edge only.
`timescale 1ns/100ps
`default_nettype none
module pms_sequencer_tb_top;
    import pms_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic chip_rst_pin_n = 1'b1;
    logic mask = 1'b0;
    pms_cfg_t cfg = '0;
    logic [15:0] en = 16'hffff;
    logic tick = 1'b0;
    logic [1:0] sdiv = 2'h1, mdiv = 2'h1;
    logic [2:0] tcnt = '0;
    logic sleep_exec, halted, wexc, dexc, busy, clk_en;
    logic [15:0] intr_req;
    pms_mode_t mode;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    always @(negedge clk) begin
        tcnt <= tcnt + 3'h1;
        tick <= (tcnt == 3'h7);
    end
    pms_sequencer u_dut (.clk(clk), .resetn(resetn),
        .chip_rst_pin_n(chip_rst_pin_n), .sleep_exec(sleep_exec),
        .interrupt_mask_bit(mask), .cfg(cfg), .subactive_divider_select(sdiv),
        .medium_divider_select(mdiv), .intr_req(intr_req), .intr_enable(en),
        .watch_clk_tick(tick), .mode(mode), .cpu_halted(halted),
        .cpu_clk_en(clk_en), .direct_exc_start(dexc), .wake_exc_start(wexc),
        .transition_busy(busy));
    pms_cpu_model u_cpu (.clk(clk), .resetn(resetn), .wake_exc_start(wexc),
        .direct_exc_start(dexc), .sleep_exec(sleep_exec), .intr_req(intr_req));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Counts CPU clock enables over n cycles once the divider has settled.
    task automatic ticks(input int n, input logic [7:0] exp);
        int k = 0;
        repeat (4) @(negedge clk);
        repeat (n) @(negedge clk) k += clk_en;
        check(k[7:0], exp);
    endtask
    task automatic wait_mode(input pms_mode_t m, input int lim);
        @(negedge clk);
        for (int i = 0; i < lim && mode !== m; i++) @(negedge clk);
        check(mode, m);
    endtask
    task automatic go(input logic [4:0] b, input pms_mode_t m, input int lim);
        @(negedge clk);
        cfg = {b, 3'b110};
        u_cpu.sleep();
        wait_mode(m, lim);
    endtask
    task automatic t_reset();
        repeat (6) @(negedge clk);
        check(mode, PMS_RESET);
        check({7'h0, halted}, 8'h01);
        resetn = 1'b1;
        wait_mode(PMS_MEDIUM, 20);
        ticks(32, 8'h08);
    endtask
    task automatic t_sleep_standby();
        go(5'b00100, PMS_SLEEP, 4);
        u_cpu.raise(16'h0002);
        wait_mode(PMS_MEDIUM, 20);
        go(5'b10100, PMS_STANDBY, 4);
        u_cpu.raise(16'h0001);
        repeat (20) @(negedge clk);
        check(mode, PMS_STANDBY);
        u_cpu.raise(16'h0040);
        wait_mode(PMS_MEDIUM, 40);
    endtask
    task automatic t_watch();
        go(5'b11101, PMS_WATCH, 4);
        mask = 1'b1;
        u_cpu.raise(16'h0001);
        repeat (10) @(negedge clk);
        check(mode, PMS_WATCH);
        mask = 1'b0;
        en = 16'hfffe;
        repeat (10) @(negedge clk);
        check(mode, PMS_WATCH);
        en = 16'hffff;
        wait_mode(PMS_SUBACT, 10);
        ticks(128, 8'h04);
        go(5'b01001, PMS_SUBSLEEP, 4);
        mask = 1'b1;
        u_cpu.raise(16'h0008);
        repeat (10) @(negedge clk);
        mask = 1'b0;
        wait_mode(PMS_SUBACT, 10);
        go(5'b10101, PMS_WATCH, 4);
        u_cpu.raise(16'h0080);
        wait_mode(PMS_MEDIUM, 40);
    endtask
    task automatic t_direct();
        logic [4:0] b [6] = '{5'b00010, 5'b00110, 5'b11011, 5'b10011,
            5'b11011, 5'b10111};
        pms_mode_t m [6] = '{PMS_HIGH, PMS_MEDIUM, PMS_SUBACT, PMS_HIGH,
            PMS_SUBACT, PMS_MEDIUM};
        foreach (b[i]) begin
            go(b[i], m[i], 60);
            for (int k = 0; k < 600 && busy !== 1'b0; k++) @(negedge clk);
            check({7'h0, busy}, 8'h00);
        end
    endtask
    task automatic t_lock();
        mask = 1'b1;
        go(5'b00010, PMS_SLEEP, 4);
        mask = 1'b0;
        u_cpu.raise(16'hffff);
        repeat (20) @(negedge clk);
        check(mode, PMS_SLEEP);
        chip_rst_pin_n = 1'b0;
        repeat (8) @(negedge clk);
        check(mode, PMS_RESET);
        chip_rst_pin_n = 1'b1;
        wait_mode(PMS_MEDIUM, 20);
        en = 16'h7fff;
        go(5'b00010, PMS_SLEEP, 4);
        repeat (20) @(negedge clk);
        check(mode, PMS_SLEEP);
    endtask
    task automatic test_done();
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        t_reset();
        t_sleep_standby();
        t_watch();
        t_direct();
        t_lock();
        test_done();
    end
endmodule
`default_nettype wire
